// ---- design/rcap_regs.sv ----
// Channel register slice: equalizer index override, lock qualifiers,
// adaptation start and mode, eye alarm, and pattern logic control.
// Assumes a synchronous 8-bit register port from the management bus logic.
`timescale 1ns/1ps
module rcap_regs
	import rcap_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       clk_en,
	// Register port.
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	// Measurements and status from the analog side.
	input  wire logic [7:0] horiz_eye_opening,
	input  wire logic [7:0] vert_eye_opening,
	input  wire logic       eye_meas_valid,
	input  wire logic       range_limit_hit,
	input  wire logic [1:0] ref_mode,
	input  wire logic       freq_offset_pass,
	input  wire logic       cdr_locked_raw,
	input  wire logic       leq_optimal,
	input  wire logic       dfe_done,
	// Equalizer and lock controls.
	output logic [4:0]      eq_setting_index,
	output logic            eq_index_override,
	output logic            frequency_lock_detector_en,
	output logic            lock_detect,
	// Adaptation controls.
	output logic            leq_adapt_active,
	output logic            dfe_adapt_active,
	output logic            adapt_busy,
	output logic            merit_use_horiz,
	output logic            merit_use_vert,
	output logic            merit_invalid,
	// Pattern logic.
	output logic            pattern_bit,
	output logic            pattern_clk_gate
);

	logic [7:0]  eq_index;
	logic [7:0]  lock_ctl;
	logic [7:0]  pat_ctl;
	logic [7:0]  mode_ctl;
	logic [7:0]  alarm_thr;
	logic [7:0]  mon_ctl;
	logic [7:0]  limits;
	logic        eye_opening_alarm_flag;
	logic        eye_monitor_range_error;
	logic        pat_en_d;
	logic        pat_restart;
	logic        below_thr;
	logic [8:0]  h_lim;
	logic [8:0]  v_lim;
	logic        wr_en;
	logic        rd_en;
	rcap_state_t state;
	rcap_state_t next_state;

	assign wr_en = clk_en && reg_wr;
	assign rd_en = clk_en && reg_rd;

	// Plain read/write configuration registers.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			eq_index  <= RST_EQ_INDEX;
			pat_ctl   <= RST_PAT_CTRL;
			mode_ctl  <= RST_ADAPT_MODE;
			alarm_thr <= RST_ALARM_THRESH;
			mon_ctl   <= RST_EYE_MON_CTL;
			limits    <= RST_EYE_LIMITS;
		end else if (wr_en) begin
			unique case (reg_addr)
				OFS_EQ_INDEX:     eq_index  <= reg_wdata;
				OFS_PAT_STATUS:   pat_ctl   <= reg_wdata & WMASK_PAT_CTRL;
				OFS_ADAPT_MODE:   mode_ctl  <= reg_wdata & WMASK_ADAPT_MODE;
				OFS_ALARM_THRESH: alarm_thr <= reg_wdata;
				OFS_EYE_MON_CTL:  mon_ctl   <= reg_wdata;
				OFS_EYE_LIMITS:   limits    <= reg_wdata;
				default:          ;
			endcase
		end
	end

	// Lock and adaptation control; start bit clears itself once taken.
	// In mode 00 the start is dropped at once, as no run would clear it.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lock_ctl <= RST_LOCK_ADAPT;
		end else if (clk_en) begin
			if (wr_en && reg_addr == OFS_LOCK_ADAPT) begin
				lock_ctl <= reg_wdata & WMASK_LOCK_ADAPT;
			end else if (state != ST_IDLE
				|| mode_ctl[B_ADAPT_MODE +: 2] == AM_NONE) begin
				lock_ctl[B_LEQ_START] <= 1'b0;
			end
		end
	end

	// Equalizer index override and lock qualifiers.
	always_comb begin
		eq_index_override = lock_ctl[B_IDX_OV];
		eq_setting_index  = eq_index[4:0];
		frequency_lock_detector_en = !(ref_mode == REF_MODE_DEFAULT
			&& lock_ctl[B_FLD_CHK]);
		lock_detect = cdr_locked_raw
			&& (!lock_ctl[B_PPM_EN] || freq_offset_pass);
	end

	// Merit select decode; code 00 flags invalid and selects nothing.
	always_comb begin
		merit_use_horiz = 1'b0;
		merit_use_vert  = 1'b0;
		merit_invalid   = 1'b0;
		unique case (mode_ctl[B_MERIT_SEL +: 2])
			MS_INVALID: merit_invalid = 1'b1;
			MS_HORIZ:   merit_use_horiz = 1'b1;
			MS_VERT:    merit_use_vert = 1'b1;
			MS_BOTH: begin
				merit_use_horiz = 1'b1;
				merit_use_vert  = 1'b1;
			end
		endcase
	end

	// Adaptation sequencer steps through the phases of the selected mode.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (lock_ctl[B_LEQ_START]
					&& mode_ctl[B_ADAPT_MODE +: 2] != AM_NONE) begin
					next_state = ST_LEQ1;
				end
			end
			ST_LEQ1: begin
				unique case (mode_ctl[B_ADAPT_MODE +: 2])
					AM_LEQ_ONLY: if (leq_optimal) next_state = ST_DONE;
					AM_LEQ_OPT:  if (leq_optimal) next_state = ST_DFE;
					AM_LEQ_LOCK: if (lock_detect) next_state = ST_DFE;
					AM_NONE:     next_state = ST_DONE;
				endcase
			end
			ST_DFE:  if (dfe_done) next_state = ST_LEQ2;
			ST_LEQ2: if (leq_optimal) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// Phase outputs follow the state directly.
	assign leq_adapt_active = state == ST_LEQ1 || state == ST_LEQ2;
	assign dfe_adapt_active = state == ST_DFE;
	assign adapt_busy       = state != ST_IDLE;

	// Threshold nibbles scale by 8 counts per step before comparison.
	always_comb begin
		h_lim = 9'(alarm_thr[B_H_THRESH +: 4]) << THRESH_LSB_SHIFT;
		v_lim = 9'(alarm_thr[3:0]) << THRESH_LSB_SHIFT;
		if (limits != RST_EYE_LIMITS) begin
			h_lim = 9'(limits[B_H_THRESH +: 4]) << THRESH_LSB_SHIFT;
			v_lim = 9'(limits[3:0]) << THRESH_LSB_SHIFT;
		end
		below_thr = 9'(horiz_eye_opening) < h_lim
			|| 9'(vert_eye_opening) < v_lim;
	end

	// Sticky alarm: a new event in the read cycle wins over the clear.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			eye_opening_alarm_flag <= 1'b0;
		end else if (clk_en) begin
			if (mon_ctl[B_ALARM_EN] && eye_meas_valid && below_thr) begin
				eye_opening_alarm_flag <= 1'b1;
			end else if (rd_en && reg_addr == OFS_PAT_STATUS) begin
				eye_opening_alarm_flag <= 1'b0;
			end
		end
	end

	// Range error mirrors the monitor's limit; no software write path.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			eye_monitor_range_error <= 1'b0;
		end else if (clk_en) begin
			eye_monitor_range_error <= range_limit_hit;
		end
	end

	// Rising edge of the pattern clock enable arms a restart.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pat_en_d <= 1'b0;
		end else if (clk_en) begin
			pat_en_d <= pat_ctl[B_PAT_CLKEN];
		end
	end

	// Turning the enable back on after off reseeds the pattern logic.
	assign pat_restart = clk_en && pat_ctl[B_PAT_CLKEN] && !pat_en_d;
	assign pattern_clk_gate = pat_ctl[B_PAT_CLKEN];

	rcap_prbs u_prbs (
		.clock       (clock),
		.arst_n      (arst_n),
		.run         (clk_en && pat_ctl[B_PAT_CLKEN]),
		.restart     (pat_restart),
		.sel         (pat_ctl[B_PAT_SEL +: 2]),
		.pattern_bit (pattern_bit)
	);

	// Registered read data; unmapped offsets read as zero.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (rd_en) begin
			unique case (reg_addr)
				OFS_EQ_INDEX:     reg_rdata <= eq_index;
				OFS_LOCK_ADAPT:   reg_rdata <= lock_ctl;
				OFS_PAT_STATUS:   reg_rdata <= pat_ctl
					| (8'(eye_monitor_range_error) << B_RANGE_ERR)
					| (8'(eye_opening_alarm_flag) << B_EYE_ALARM);
				OFS_ADAPT_MODE:   reg_rdata <= mode_ctl;
				OFS_ALARM_THRESH: reg_rdata <= alarm_thr;
				OFS_EYE_MON_CTL:  reg_rdata <= mon_ctl;
				OFS_EYE_LIMITS:   reg_rdata <= limits;
				default:          reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule : rcap_regs

// ---- design/rcap_pkg.sv ----
// Package for the retimer channel adaptation and pattern control slice.
// Assumes an 8-bit management register port on the internal register clock.
package rcap_pkg;

	// Register offsets.
	localparam logic [7:0] OFS_EQ_INDEX     = 8'h13;
	localparam logic [7:0] OFS_LOCK_ADAPT   = 8'h2F;
	localparam logic [7:0] OFS_PAT_STATUS   = 8'h30;
	localparam logic [7:0] OFS_ADAPT_MODE   = 8'h31;
	localparam logic [7:0] OFS_ALARM_THRESH = 8'h32;
	localparam logic [7:0] OFS_EYE_MON_CTL  = 8'h36;
	localparam logic [7:0] OFS_EYE_LIMITS   = 8'h76;

	// Field positions in the lock and adaptation control register.
	localparam int B_SUBRATE_FIELD_BIT0  = 4;
	localparam int B_IDX_OV    = 3;
	localparam int B_PPM_EN    = 2;
	localparam int B_FLD_CHK   = 1;
	localparam int B_LEQ_START = 0;

	// Field positions in the pattern and alarm status register.
	localparam int B_RANGE_ERR = 5;
	localparam int B_EYE_ALARM = 4;
	localparam int B_PAT_CLKEN = 3;
	localparam int B_PAT_SEL   = 0;

	// Field positions in the adaptation mode register.
	localparam int B_ADAPT_MODE = 5;
	localparam int B_MERIT_SEL  = 3;

	// Alarm enable bit in the eye monitor control register.
	localparam int B_ALARM_EN = 6;

	// Threshold fields: high nibble horizontal, low nibble vertical.
	localparam int B_H_THRESH = 4;
	localparam int THRESH_LSB_SHIFT = 3;

	// Reset values.
	localparam logic [7:0] RST_EQ_INDEX     = 8'h00;
	localparam logic [7:0] RST_LOCK_ADAPT   = 8'h06;
	localparam logic [7:0] RST_PAT_CTRL     = 8'h00;
	localparam logic [7:0] RST_ADAPT_MODE   = 8'h20;
	localparam logic [7:0] RST_ALARM_THRESH = 8'h11;
	localparam logic [7:0] RST_EYE_MON_CTL  = 8'h00;
	localparam logic [7:0] RST_EYE_LIMITS   = 8'h00;

	// Writable masks, reserved and read-only bits excluded.
	localparam logic [7:0] WMASK_LOCK_ADAPT = 8'hFF;
	localparam logic [7:0] WMASK_PAT_CTRL   = 8'h0B;
	localparam logic [7:0] WMASK_ADAPT_MODE = 8'h78;

	// Pattern select codes.
	localparam logic [1:0] PAT_PRBS7  = 2'h0;
	localparam logic [1:0] PAT_PRBS9  = 2'h1;
	localparam logic [1:0] PAT_PRBS15 = 2'h2;
	localparam logic [1:0] PAT_PRBS31 = 2'h3;

	// Adaptation mode codes.
	localparam logic [1:0] AM_NONE     = 2'h0;
	localparam logic [1:0] AM_LEQ_ONLY = 2'h1;
	localparam logic [1:0] AM_LEQ_OPT  = 2'h2;
	localparam logic [1:0] AM_LEQ_LOCK = 2'h3;

	// Merit select codes.
	localparam logic [1:0] MS_INVALID = 2'h0;
	localparam logic [1:0] MS_HORIZ   = 2'h1;
	localparam logic [1:0] MS_VERT    = 2'h2;
	localparam logic [1:0] MS_BOTH    = 2'h3;

	// Reference clock mode in which the lock detector check bit applies.
	localparam logic [1:0] REF_MODE_DEFAULT = 2'h3;

	// Adaptation sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_LEQ1  = 5'b00010,
		ST_DFE   = 5'b00100,
		ST_LEQ2  = 5'b01000,
		ST_DONE  = 5'b10000
	} rcap_state_t;

endpackage : rcap_pkg

// ---- design/rcap_prbs.sv ----
// Pattern generator for the channel slice: PRBS-7/9/15/31 by select.
// Assumes the clock enable gating and restart come from the register slice.
`timescale 1ns/1ps
module rcap_prbs
	import rcap_pkg::*;
(
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Control.
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [1:0] sel,
	// Pattern output.
	output logic            pattern_bit
);

	logic [30:0] lfsr;
	logic        fb;

	// Feedback taps per selected polynomial.
	always_comb begin
		unique case (sel)
			PAT_PRBS7:  fb = lfsr[6] ^ lfsr[5];
			PAT_PRBS9:  fb = lfsr[8] ^ lfsr[4];
			PAT_PRBS15: fb = lfsr[14] ^ lfsr[13];
			PAT_PRBS31: fb = lfsr[30] ^ lfsr[27];
		endcase
	end

	// Shift only while clocked; restart reseeds to all ones.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lfsr        <= '1;
			pattern_bit <= 1'b0;
		end else if (restart) begin
			lfsr        <= '1;
			pattern_bit <= 1'b0;
		end else if (run) begin
			lfsr        <= {lfsr[29:0], fb};
			pattern_bit <= fb;
		end
	end

endmodule : rcap_prbs

// ---- verif/rcap_regs_assertions.sv ----
// Port-level assertions for the channel register slice.
// Bound to rcap_regs; assumes clk_en stays high around adaptation starts.
`timescale 1ns/1ps
module rcap_regs_assertions import rcap_pkg::*; (
	// Watched ports.
	input wire logic       clock, arst_n, clk_en, reg_wr, reg_rd,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [1:0] ref_mode,
	input wire logic       freq_offset_pass, cdr_locked_raw, range_limit_hit,
	input wire logic       eye_meas_valid, lock_detect,
	input wire logic       frequency_lock_detector_en,
	input wire logic [4:0] eq_setting_index,
	input wire logic       adapt_busy, leq_adapt_active,
	input wire logic       merit_use_horiz, merit_use_vert, merit_invalid,
	input wire logic       pattern_bit, pattern_clk_gate
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [1:0] mode;
	// Shadow of the mode field, since a start in mode 00 runs nothing.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			mode <= 2'h1;
		else if (clk_en && reg_wr && reg_addr == OFS_ADAPT_MODE)
			mode <= reg_wdata[6:5];
	end
	sequence s_wr(a, m);
		clk_en && reg_wr && reg_addr == a && (reg_wdata & m) == m;
	endsequence
	sequence s_rd30q;
		clk_en && reg_rd && reg_addr == OFS_PAT_STATUS && !eye_meas_valid;
	endsequence
	sequence s_start;
		clk_en && reg_wr && reg_addr == OFS_LOCK_ADAPT && reg_wdata[0]
			&& mode != 2'h0 && !adapt_busy;
	endsequence
	property p_idx;
		s_wr(OFS_EQ_INDEX, 8'h00) |=> eq_setting_index == $past(reg_wdata[4:0]);
	endproperty
	property p_ppm;
		s_wr(OFS_LOCK_ADAPT, 8'h04) ##1 !freq_offset_pass |-> !lock_detect;
	endproperty
	property p_raw;
		!cdr_locked_raw |-> !lock_detect;
	endproperty
	property p_fld;
		s_wr(OFS_LOCK_ADAPT, 8'h00) ##1 ref_mode == REF_MODE_DEFAULT
			|-> frequency_lock_detector_en == !$past(reg_wdata[1]);
	endproperty
	property p_start;
		s_start ##1 clk_en |=> adapt_busy && leq_adapt_active;
	endproperty
	property p_merit;
		s_wr(OFS_ADAPT_MODE, 8'h00) |=> merit_use_horiz == $past(reg_wdata[3])
			&& merit_use_vert == $past(reg_wdata[4])
			&& merit_invalid == ($past(reg_wdata[4:3]) == 2'h0);
	endproperty
	property p_clr;
		s_rd30q ##1 !eye_meas_valid ##1 s_rd30q |=> !reg_rdata[4];
	endproperty
	property p_rng;
		(clk_en && range_limit_hit) ##1 (clk_en && reg_rd
			&& reg_addr == OFS_PAT_STATUS && range_limit_hit)
			|=> reg_rdata[5] && reg_rdata[7:6] == 2'h0;
	endproperty
	property p_gate;
		s_wr(OFS_PAT_STATUS, 8'h00) |=> pattern_clk_gate == $past(reg_wdata[3]);
	endproperty
	property p_hold;
		!pattern_clk_gate ##1 !pattern_clk_gate |-> $stable(pattern_bit);
	endproperty
	a_idx: assert property (p_idx) else $error("index mismatch");
	a_ppm: assert property (p_ppm) else $error("lock without pass");
	a_raw: assert property (p_raw) else $error("lock without cdr");
	a_fld: assert property (p_fld) else $error("detector enable");
	a_start: assert property (p_start) else $error("run not begun");
	a_merit: assert property (p_merit) else $error("merit decode");
	a_clr: assert property (p_clr) else $error("alarm not cleared");
	a_rng: assert property (p_rng) else $error("range bit");
	a_gate: assert property (p_gate) else $error("gate bit");
	a_hold: assert property (p_hold) else $error("pattern moved");
endmodule : rcap_regs_assertions

bind rcap_regs rcap_regs_assertions rcap_regs_assertions_i (.clock, .arst_n,
	.clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ref_mode,
	.freq_offset_pass, .cdr_locked_raw, .range_limit_hit, .eye_meas_valid,
	.lock_detect, .frequency_lock_detector_en, .eq_setting_index, .adapt_busy,
	.leq_adapt_active, .merit_use_horiz, .merit_use_vert, .merit_invalid,
	.pattern_bit, .pattern_clk_gate);

// ---- verif/rcap_regs_test.sv ----
// Self-checking bench for the channel register slice.
// Drives every input 1 ns after the rising edge of a 4 ns clock.
`timescale 1ns/1ps
module rcap_regs_test import rcap_pkg::*;;
	logic clock, arst_n, clk_en, reg_wr, reg_rd, eye_meas_valid, dfe_done;
	logic range_limit_hit, freq_offset_pass, cdr_locked_raw, leq_optimal;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, horiz_eye_opening, d;
	logic [7:0] vert_eye_opening;
	logic [1:0] ref_mode;
	logic [4:0] eq_setting_index;
	logic eq_index_override, frequency_lock_detector_en, lock_detect;
	logic leq_adapt_active, dfe_adapt_active, adapt_busy, merit_use_horiz;
	logic merit_use_vert, merit_invalid, pattern_bit, pattern_clk_gate;
	logic s [0:599];
	int n_mismatch, compares;
	rcap_regs rcap_regs_i (.clock, .arst_n, .clk_en, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .horiz_eye_opening,
		.vert_eye_opening, .eye_meas_valid, .range_limit_hit, .ref_mode,
		.freq_offset_pass, .cdr_locked_raw, .leq_optimal, .dfe_done,
		.eq_setting_index, .eq_index_override, .frequency_lock_detector_en,
		.lock_detect, .leq_adapt_active, .dfe_adapt_active, .adapt_busy,
		.merit_use_horiz, .merit_use_vert, .merit_invalid, .pattern_bit,
		.pattern_clk_gate);
	// Free-running register clock.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	// Bus cycles hold the strobe for exactly one taking edge.
	task automatic wr(input logic [7:0] a, v);
		cyc(1);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		cyc(1);
		{reg_rd, reg_addr} = {1'b1, a};
		cyc(1);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	// Bounded wait: 0 linear stage, 1 feedback stage, 2 idle.
	task automatic wt(input int k);
		for (int i = 0; i < 50; i++) begin
			if (k == 0 && leq_adapt_active === 1'b1) return;
			if (k == 1 && dfe_adapt_active === 1'b1) return;
			if (k == 2 && adapt_busy === 1'b0) return;
			cyc(1);
		end
		chk("wait", 8'h00, 8'h01);
		end_sim;
	endtask : wt
	task automatic t_regs;
		logic [7:0] a [8] = '{8'h13, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h36,
			8'h76, 8'h55};
		logic [7:0] r [8] = '{8'h00, 8'h06, 8'h00, 8'h20, 8'h11, 8'h00,
			8'h00, 8'h00};
		foreach (a[i]) begin
			rd(a[i]);
			chk("reset", d, r[i]);
		end
		wr(8'h30, 8'hFF); rd(8'h30); chk("r30", d, 8'h0B);
		wr(8'h31, 8'hFF); rd(8'h31); chk("r31", d, 8'h78);
		wr(8'h2F, 8'hFE); wr(8'h13, 8'h1F); wr(8'h55, 8'hFF); rd(8'h55);
		chk("unmapped", d, 8'h00);
		chk("index", {eq_index_override, eq_setting_index}, 8'h3F);
		clk_en = 1'b0; wr(8'h13, 8'h0A); clk_en = 1'b1;
		chk("frozen", eq_setting_index, 8'h1F);
		wr(8'h30, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_lock;
		wr(8'h2F, 8'h06); cdr_locked_raw = 1'b1; cyc(1);
		chk("fld off", frequency_lock_detector_en, 0);
		chk("ppm gate", lock_detect, 0);
		ref_mode = 2'h2;
		cyc(1);
		chk("other mode", frequency_lock_detector_en, 1);
		ref_mode = 2'h3;
		freq_offset_pass = 1'b1; cyc(1);
		chk("ppm pass", lock_detect, 1);
		freq_offset_pass = 1'b0; wr(8'h2F, 8'h00);
		chk("fld on", frequency_lock_detector_en, 1);
		chk("no ppm", lock_detect, 1);
		cdr_locked_raw = 1'b0; cyc(1);
		chk("unlocked", lock_detect, 0);
		$display("t_lock done");
	endtask : t_lock
	task automatic t_adapt;
		logic [2:0] g;
		for (int m = 0; m < 4; m++) begin
			wr(OFS_ADAPT_MODE, 8'(m << 3));
			g = {merit_invalid, merit_use_vert, merit_use_horiz};
			chk("merit", g, {m == 0, 2'(m)});
		end
		wr(8'h2F, 8'h01); cyc(3);
		chk("mode0", adapt_busy, 0);
		rd(8'h2F);
		chk("mode0 clr", d, 8'h00);
		wr(8'h31, 8'h20); wr(8'h2F, 8'h01); wt(0);
		chk("mode1", dfe_adapt_active, 0);
		rd(8'h2F); chk("selfclr", d, 8'h00);
		leq_optimal = 1'b1; wt(2); leq_optimal = 1'b0;
		wr(8'h31, 8'h40); wr(8'h2F, 8'h01); wt(0);
		leq_optimal = 1'b1; wt(1); leq_optimal = 1'b0;
		dfe_done = 1'b1; wt(0); dfe_done = 1'b0;
		chk("mode2 again", leq_adapt_active, 1);
		leq_optimal = 1'b1; wt(2); leq_optimal = 1'b0;
		wr(8'h31, 8'h60); wr(8'h2F, 8'h01); wt(0);
		leq_optimal = 1'b1; cyc(3); leq_optimal = 1'b0;
		chk("mode3 waits", leq_adapt_active, 1);
		{cdr_locked_raw, freq_offset_pass} = 2'h3; wt(1);
		dfe_done = 1'b1; wt(0); dfe_done = 1'b0;
		leq_optimal = 1'b1; wt(2); leq_optimal = 1'b0;
		{cdr_locked_raw, freq_offset_pass} = 2'h0;
		$display("t_adapt done");
	endtask : t_adapt
	// One qualified measurement, then a read of the status register.
	task automatic meas(input logic [7:0] h, v);
		{eye_meas_valid, horiz_eye_opening, vert_eye_opening} = {1'b1, h, v};
		cyc(1);
		eye_meas_valid = 1'b0;
		rd(8'h30);
	endtask : meas
	task automatic t_alarm;
		meas(8'h00, 8'h00); chk("disabled", d[4], 0);
		wr(8'h36, 8'h40);
		meas(8'h08, 8'h08); chk("at limit", d[4], 0);
		meas(8'h08, 8'h07); chk("below", d[4], 1);
		rd(8'h30); chk("cleared", d[4], 0);
		wr(8'h32, 8'h22);
		meas(8'h10, 8'h10); chk("x8 limit", d[4], 0);
		meas(8'h0F, 8'h14); chk("x8 below", d[4], 1);
		wr(8'h76, 8'h33);
		meas(8'h18, 8'h18);
		chk("limits at", d[4], 0);
		meas(8'h20, 8'h17);
		chk("limits below", d[4], 1);
		eye_meas_valid = 1'b1;
		horiz_eye_opening = 8'h00;
		rd(8'h30);
		eye_meas_valid = 1'b0;
		chk("set wins", d[4], 1);
		rd(8'h30);
		chk("held", d[4], 1);
		rd(8'h30);
		chk("clear", d[4], 0);
		range_limit_hit = 1'b1; rd(8'h30); range_limit_hit = 1'b0;
		chk("range", d[5], 1);
		$display("t_alarm done");
	endtask : t_alarm
	task automatic t_pat;
		int e7, e9;
		logic p;
		p = pattern_bit; cyc(20); chk("gated", pattern_bit, p);
		for (int k = 3; k >= 0; k--) begin
			wr(8'h30, 8'h00); wr(8'h30, 8'(8 + k));
			for (int i = 0; i < 600; i++) begin
				s[i] = pattern_bit; cyc(1);
			end
			{e7, e9} = 0;
			for (int i = 8; i < 72; i++) begin
				e7 += int'(s[i] !== s[i + 127]);
				e9 += int'(s[i] !== s[i + 511]);
			end
			chk("period", {e7 != 0, e9 != 0}, {k != 0, k != 1});
		end
		wr(8'h30, 8'h00); wr(8'h30, 8'h08);
		cyc(1);
		for (int i = 1; i < 17; i++) begin
			chk("restart", pattern_bit, s[i]); cyc(1);
		end
		$display("t_pat done");
	endtask : t_pat
	initial begin
		{arst_n, reg_wr, reg_rd, eye_meas_valid, dfe_done} = 5'h0;
		{range_limit_hit, freq_offset_pass, cdr_locked_raw, leq_optimal} = 4'h0;
		{reg_addr, reg_wdata, horiz_eye_opening, vert_eye_opening} = 32'h0;
		{clk_en, ref_mode, n_mismatch, compares} = {1'b1, 2'h3, 64'h0};
		repeat (3) @(posedge clock);
		#1 arst_n = 1'b1;
		t_regs; t_lock; t_adapt; t_alarm; t_pat;
		end_sim;
	end
endmodule : rcap_regs_test
